// *** rtl/sspi_regs.svh ***
`ifndef SSPI_REGS_SVH
`define SSPI_REGS_SVH
`define SSPI_ADDR_W 7
`define SSPI_DATA_W 8
`define SSPI_BIT_CNT_W 5
`define SSPI_ADDR_LAST_BIT 5'h07
`define SSPI_DUMMY_LAST_BIT 5'h0F
`define SSPI_DATA_LAST_BIT 5'h17
`define SSPI_DATA_FIRST_BIT 5'h10
`define SSPI_BYTE_RESTART 5'h10
`define SSPI_CONFIG_FIRST_ADDR 7'h15
`define SSPI_WIRE_MODE_BIT 0
`define SSPI_RESET_BYTE 8'h00
`endif

// *** rtl/sspi_pkg.sv ***
package sspi_pkg;
  typedef enum logic [1:0] {
    SSPI_IDLE = 2'b00,
    SSPI_HEADER = 2'b01,
    SSPI_DATA = 2'b10
  } sspi_state_t;
  typedef logic [7:0] sspi_byte_t;
  typedef logic [6:0] sspi_addr_t;
endpackage : sspi_pkg

// *** rtl/sspi_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module sspi_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic async_in,
  input wire logic reset_value,
  output logic sync_out
);
  logic stage1;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      stage1 <= async_in ^ reset_value;
      sync_out <= stage1;
    end
  end
endmodule : sspi_sync
`default_nettype wire

// *** rtl/sspi_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sspi_regs.svh"
module sspi_port (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic soft_reset,
  input wire logic spi_select_n,
  input wire logic spi_clk,
  input wire logic spi_data_in,
  input wire logic spi_data_io_in,
  output logic spi_data_out,
  output logic spi_data_out_en,
  output logic spi_data_io_out,
  output logic spi_data_io_en,
  output logic three_wire_mode,
  output logic reg_wr_en,
  output sspi_pkg::sspi_addr_t reg_addr,
  output sspi_pkg::sspi_byte_t reg_wr_data,
  input wire sspi_pkg::sspi_byte_t reg_rd_data
);
  import sspi_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic selected_s;
  logic clk_s;
  logic din_s;
  logic dio_s;
  logic clk_d;
  logic sel_d;
  logic clk_rise;
  logic clk_fall;
  logic sel_rise;
  logic active;
  logic in_bit;

  // The select pin is inverted on entry, so the synchronised level is high while
  // the host selects us, and its reset value of zero reads as deselected.
  // The serial clock is oversampled, so each of its phases must last at least two
  // reference cycles; a faster host loses edges.
  sspi_sync u_sync_sel (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(spi_select_n),
    .reset_value(1'b1),
    .sync_out(selected_s)
  );
  sspi_sync u_sync_clk (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(spi_clk),
    .reset_value(1'b0),
    .sync_out(clk_s)
  );
  sspi_sync u_sync_din (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(spi_data_in),
    .reset_value(1'b0),
    .sync_out(din_s)
  );
  sspi_sync u_sync_dio (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(spi_data_io_in),
    .reset_value(1'b0),
    .sync_out(dio_s)
  );

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Both delay stages reset to the idle level of their line, so reset makes no false edge.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      clk_d <= 1'b0;
      sel_d <= 1'b0;
    end
    else
    begin
      clk_d <= clk_s;
      sel_d <= selected_s;
    end
  end

  // High while the host keeps the select line released.
  logic sel_high;
  assign sel_high = ~selected_s;
  assign active = ~sel_high;
  assign clk_rise = active & clk_s & ~clk_d;
  assign clk_fall = active & ~clk_s & clk_d;
  assign sel_rise = ~selected_s & sel_d;
  assign in_bit = three_wire_mode ? dio_s : din_s;

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  sspi_state_t state;
  logic [`SSPI_BIT_CNT_W-1:0] bit_cnt;
  logic rd_dir;
  sspi_byte_t shift_in;
  sspi_byte_t shift_out;
  logic [`SSPI_BIT_CNT_W-1:0] next_bit_cnt;

  // After rise 16 and after every full data byte the counter stands at 16 again.
  assign next_bit_cnt = (bit_cnt == `SSPI_DATA_LAST_BIT) ? `SSPI_BYTE_RESTART
                                                         : bit_cnt + 5'h01;

  // Select high wins over a clock edge, so a cut frame never advances the count.
  // host starts every frame
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= SSPI_IDLE;
      bit_cnt <= '0;
    end
    else if (sel_high)
    begin
      state <= SSPI_IDLE;
      bit_cnt <= '0;
    end
    else if (clk_rise)
    begin
      bit_cnt <= (state == SSPI_IDLE) ? 5'h01 : next_bit_cnt;
      unique case (state)
        SSPI_IDLE: state <= SSPI_HEADER;
        SSPI_HEADER: state <= (bit_cnt == `SSPI_DUMMY_LAST_BIT) ? SSPI_DATA : SSPI_HEADER;
        SSPI_DATA: state <= SSPI_DATA;
        default: state <= SSPI_IDLE;
      endcase
    end
  end

  // The direction is kept for the whole frame, since reads and writes differ only after bit 16.
  // first bit direction
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rd_dir <= 1'b0;
    else if (clk_rise && state == SSPI_IDLE)
      rd_dir <= in_bit;
    else if (sel_rise)
      rd_dir <= 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      shift_in <= `SSPI_RESET_BYTE;
    else if (clk_rise)
      shift_in <= {shift_in[6:0], in_bit};
  end

  // ----------------------------------------------------------------
  // Address and register write
  // ----------------------------------------------------------------
  logic byte_done;
  sspi_byte_t rx_byte;
  logic advance;
  assign byte_done = clk_rise && state == SSPI_DATA && bit_cnt == `SSPI_DATA_LAST_BIT;
  // The byte is complete on the edge that brings its last bit.
  assign rx_byte = {shift_in[6:0], in_bit};
  // A write moves the pointer only with its store pulse, so the store still lands in the
  // addressed register; a read moves it at once, so the reload fetches the next one.
  assign advance = (byte_done && rd_dir) || reg_wr_en;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      reg_addr <= '0;
    else if (clk_rise && state == SSPI_HEADER && bit_cnt == `SSPI_ADDR_LAST_BIT)
      reg_addr <= {shift_in[5:0], in_bit};
    else if (advance)
      reg_addr <= reg_addr + 7'h01;
  end

  // The strobe is registered, so pointer, data and strobe leave the block together.
  // dummy byte discarded
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_wr_en <= 1'b0;
      reg_wr_data <= `SSPI_RESET_BYTE;
    end
    else
    begin
      reg_wr_en <= byte_done & ~rd_dir & ~sel_high;
      if (byte_done && !rd_dir)
        reg_wr_data <= rx_byte;
    end
  end

  // A soft reset wins over a write in the same cycle; it clears only the wire mode, back to four-wire.
  // four-wire after reset
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      three_wire_mode <= 1'b0;
    else if (soft_reset)
      three_wire_mode <= 1'b0;
    else if (byte_done && !rd_dir && reg_addr == `SSPI_CONFIG_FIRST_ADDR)
      three_wire_mode <= rx_byte[`SSPI_WIRE_MODE_BIT];
  end

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  // The register is loaded at the end of the dummy byte or of a data byte,
  // so the first bit is ready before the falling edge that starts the byte.
  logic load_rd;
  logic out_en;
  assign load_rd = clk_rise && rd_dir &&
                   ((state == SSPI_HEADER && bit_cnt == `SSPI_DUMMY_LAST_BIT) ||
                    (state == SSPI_DATA && bit_cnt == `SSPI_DATA_LAST_BIT));

  // One cycle of delay lets the pointer settle before the register file is read.
  logic load_pending;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      load_pending <= 1'b0;
    else
      load_pending <= load_rd & ~sel_high;
  end

  // MSB first on 17 to 24
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      shift_out <= `SSPI_RESET_BYTE;
      out_en <= 1'b0;
    end
    else if (sel_high)
    begin
      out_en <= 1'b0;
    end
    else if (load_pending)
    begin
      shift_out <= reg_rd_data;
      out_en <= 1'b1;
    end
    else if (clk_fall && out_en && bit_cnt != `SSPI_BYTE_RESTART)
      shift_out <= {shift_out[6:0], 1'b0};
  end

  // The pins float only through the enables; the data bits keep their last value.
  // output undriven deselected
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      spi_data_out <= 1'b0;
      spi_data_out_en <= 1'b0;
      spi_data_io_out <= 1'b0;
      spi_data_io_en <= 1'b0;
    end
    else
    begin
      spi_data_out <= shift_out[7];
      spi_data_io_out <= shift_out[7];
      spi_data_out_en <= out_en & ~sel_high & ~three_wire_mode;
      spi_data_io_en <= out_en & ~sel_high & three_wire_mode;
    end
  end
endmodule : sspi_port
`default_nettype wire

// *** verification/sspi_port_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module sspi_port_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic soft_reset,
  input wire logic spi_select_n,
  input wire logic spi_data_out_en,
  input wire logic spi_data_io_en,
  input wire logic three_wire_mode,
  input wire logic reg_wr_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence sel_idle;
    spi_select_n [*4];
  endsequence
  sequence sel_long;
    sel_idle ##1 sel_idle;
  endsequence
  chk_out_idle:
    assert property (sel_idle |-> !spi_data_out_en) else $error("out enable while idle");
  chk_io_idle:
    assert property (sel_idle |-> !spi_data_io_en) else $error("io enable while idle");
  chk_no_wr_idle:
    assert property (sel_long |-> !reg_wr_en) else $error("write while idle");
  chk_wr_pulse:
    assert property (reg_wr_en |=> !reg_wr_en) else $error("write pulse too long");
  chk_wr_in_frame:
    assert property (reg_wr_en |-> !$past(spi_select_n, 4)) else $error("write outside frame");
  chk_en_excl:
    assert property (!(spi_data_out_en && spi_data_io_en)) else $error("both enables high");
  chk_three_wire:
    assert property (spi_data_io_en |-> three_wire_mode) else $error("io drive in four-wire");
  chk_mode_reset:
    assert property (soft_reset [*2] |=> !three_wire_mode) else $error("mode kept over reset");
endmodule : sspi_port_sva
bind sspi_port sspi_port_sva u_sva (.ref_clk(ref_clk), .rst(rst), .soft_reset(soft_reset),
  .spi_select_n(spi_select_n), .spi_data_out_en(spi_data_out_en), .spi_data_io_en(spi_data_io_en),
  .three_wire_mode(three_wire_mode), .reg_wr_en(reg_wr_en));
`default_nettype wire

// *** verification/sspi_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module sspi_host (
  input wire logic ref_clk,
  input wire logic three_wire,
  input wire logic dut_out,
  input wire logic dut_out_en,
  input wire logic dut_io_out,
  input wire logic dut_io_en,
  output var logic spi_select_n,
  output var logic spi_clk,
  output var logic spi_data_in,
  output logic spi_data_io_in
);
  import sspi_pkg::*;
  logic drv = 1'b0;
  logic bit_out = 1'b0;
  logic last = 1'b0;
  logic miso_q = 1'b0;
  logic out_last = 1'b0;
  logic miso_line;
  initial
  begin
    spi_select_n = 1'b1;
    spi_clk = 1'b0;
    spi_data_in = 1'b0;
  end
  // A released line shows the inverse of what was last driven on it, so a late
  // enable or a stale bit cannot pass for real data.
  assign spi_data_io_in = dut_io_en ? dut_io_out : (drv ? bit_out : ~last);
  assign miso_line = dut_out_en ? dut_out : ~out_last;
  always_ff @(posedge ref_clk)
  begin
    if (dut_io_en || drv)
      last <= spi_data_io_in;
    if (dut_out_en)
      out_last <= dut_out;
    miso_q <= three_wire ? spi_data_io_in : miso_line;
  end
  task automatic half();
    repeat (4) @(posedge ref_clk);
  endtask : half
  task automatic frame(input logic rd, input sspi_addr_t a, input int n, inout sspi_byte_t d [4]);
    logic [47:0] tx;
    logic [47:0] rx;
    tx = {rd, a, 8'h5A, d[0], d[1], d[2], d[3]};
    rx = '0;
    spi_select_n <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      spi_data_in <= tx[47 - i];
      bit_out <= tx[47 - i];
      drv <= three_wire && !(rd && i >= 16);
      half();
      spi_clk <= 1'b1;
      half();
      rx = {rx[46:0], miso_q};
      spi_clk <= 1'b0;
    end
    half();
    spi_select_n <= 1'b1;
    drv <= 1'b0;
    spi_data_in <= ~spi_data_in;
    half();
    half();
    for (int k = 0; k < 4; k++)
      if (rd && n >= 24 + 8 * k)
        d[k] = rx[n - 17 - 8 * k -: 8];
  endtask : frame
endmodule : sspi_host
`default_nettype wire

// *** verification/sensor_spi_register_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module sensor_spi_register_port_tb;
  import sspi_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic soft_reset = 1'b0;
  logic tw = 1'b0;
  logic spi_select_n, spi_clk, spi_data_in, spi_data_io_in, spi_data_out, spi_data_out_en;
  logic spi_data_io_out, spi_data_io_en, three_wire_mode, reg_wr_en;
  sspi_addr_t reg_addr;
  sspi_byte_t reg_wr_data, reg_rd_data;
  sspi_byte_t regs [128];
  sspi_byte_t d [4];
  int bad_count = 0;
  int cmp_count = 0;
  always #20 ref_clk = ~ref_clk;
  assign reg_rd_data = regs[reg_addr];
  always @(posedge ref_clk)
    if (reg_wr_en)
      regs[reg_addr] <= reg_wr_data;
  sspi_port u_dut (.ref_clk(ref_clk), .rst(rst), .soft_reset(soft_reset), .spi_select_n(spi_select_n),
    .spi_clk(spi_clk), .spi_data_in(spi_data_in), .spi_data_io_in(spi_data_io_in), .spi_data_out(spi_data_out),
    .spi_data_out_en(spi_data_out_en), .spi_data_io_out(spi_data_io_out), .spi_data_io_en(spi_data_io_en),
    .three_wire_mode(three_wire_mode), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data));
  sspi_host u_host (.ref_clk(ref_clk), .three_wire(tw), .dut_out(spi_data_out), .dut_out_en(spi_data_out_en),
    .dut_io_out(spi_data_io_out),
    .dut_io_en(spi_data_io_en), .spi_select_n(spi_select_n), .spi_clk(spi_clk), .spi_data_in(spi_data_in),
    .spi_data_io_in(spi_data_io_in));
  function automatic sspi_byte_t orig(input int i);
    return 8'(i) ^ 8'hC3;
  endfunction : orig
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic t_write_burst();
    d = '{8'h11, 8'h22, 8'h33, 8'h00};
    u_host.frame(1'b0, 7'h20, 40, d);
    for (int k = 0; k < 3; k++)
      chk("wr", 8'(8'h11 * (k + 1)), regs[32 + k]);
    chk("wr_next", orig(35), regs[35]);
  endtask : t_write_burst
  task automatic t_read_burst();
    d = '{default: 8'h00};
    u_host.frame(1'b1, 7'h1F, 40, d);
    chk("rd0", orig(31), d[0]);
    chk("rd1", 8'h11, d[1]);
    chk("rd2", 8'h22, d[2]);
  endtask : t_read_burst
  task automatic t_abort();
    d = '{default: 8'h99};
    u_host.frame(1'b0, 7'h30, 20, d);
    chk("abort", orig(48), regs[48]);
  endtask : t_abort
  task automatic t_three_wire();
    chk("mode0", 8'h00, {7'h00, three_wire_mode});
    d = '{default: 8'h01};
    u_host.frame(1'b0, 7'h15, 24, d);
    chk("mode1", 8'h01, {7'h00, three_wire_mode});
    tw <= 1'b1;
    @(posedge ref_clk);
    d = '{default: 8'h00};
    u_host.frame(1'b1, 7'h21, 24, d);
    chk("rd3w", 8'h22, d[0]);
    soft_reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    soft_reset <= 1'b0;
    tw <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("mode_sr", 8'h00, {7'h00, three_wire_mode});
  endtask : t_three_wire
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial
  begin
    for (int i = 0; i < 128; i++)
      regs[i] = orig(i);
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_write_burst();
    t_read_burst();
    t_abort();
    t_three_wire();
    end_of_test();
  end
  initial
  begin
    #2000000;
    bad_count++;
    end_of_test();
  end
endmodule : sensor_spi_register_port_tb
`default_nettype wire
